// ### src/nsxte_core.sv
// executes the four single-word instructions written over apb on an internal register file
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module nsxte_core #(
    parameter int ADDR_W = 8,
    parameter int NFILE  = 32
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [7:0]        port_a_direction_reg,
    output logic      [7:0]        port_b_direction_reg,
    output logic      [7:0]        port_c_direction_reg
);

    // ---------------------------------------------------------------
    // decode function
    // ---------------------------------------------------------------
    function automatic nsxte_pkg::nsxte_dec_t decode(input logic [11:0] opc);
        nsxte_pkg::nsxte_dec_t d;
        d.dest  = opc[nsxte_pkg::DEST_BIT];
        d.faddr = opc[4:0];
        d.lit   = opc[7:0];
        d.sel   = opc[2:0];
        if (opc[11:6] == nsxte_pkg::PAT_SWAP)
            d.op = nsxte_pkg::NSXTE_OP_SWAP;
        else if (opc[11:6] == nsxte_pkg::PAT_XORF)
            d.op = nsxte_pkg::NSXTE_OP_XORF;
        else if (opc[11:8] == nsxte_pkg::PAT_XORL)
            d.op = nsxte_pkg::NSXTE_OP_XORL;
        else if (opc[11:3] == nsxte_pkg::PAT_DIRLD && opc[2:0] >= nsxte_pkg::DIR_SEL_MIN)
            d.op = nsxte_pkg::NSXTE_OP_DIRLD;
        else
            d.op = nsxte_pkg::NSXTE_OP_NONE;
        return d;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0]  file_r [NFILE];
    logic [7:0]  dir_r  [3];
    logic [7:0]  acc_r;
    logic [2:0]  status_r;
    logic [11:0] opcode_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire        access   = psel & penable;
    wire        done     = access & pready_r;       // completing edge
    wire        wr_done  = done & pwrite & pstrb[0];
    wire [7:0]  addr8    = 8'(paddr);
    wire        hit_file = addr8[nsxte_pkg::FILE_SEL_BIT];
    wire [4:0]  file_idx = addr8[nsxte_pkg::FILE_IDX_MSB:nsxte_pkg::FILE_IDX_LSB];
    wire        hit_opc  = ~hit_file & (addr8 == nsxte_pkg::OFF_OPCODE);
    wire        hit_acc  = ~hit_file & (addr8 == nsxte_pkg::OFF_ACC);
    wire        hit_st   = ~hit_file & (addr8 == nsxte_pkg::OFF_STATUS);
    wire        hit_da   = ~hit_file & (addr8 == nsxte_pkg::OFF_DIR_A);
    wire        hit_db   = ~hit_file & (addr8 == nsxte_pkg::OFF_DIR_B);
    wire        hit_dc   = ~hit_file & (addr8 == nsxte_pkg::OFF_DIR_C);
    wire        mapped   = hit_file | hit_opc | hit_acc | hit_st | hit_da | hit_db | hit_dc;

    // read mux, bits above the register width read as zero
    wire [31:0] rdata =
        hit_file ? {24'h000000, file_r[file_idx]} :
        hit_opc  ? {20'h00000, opcode_r} :
        hit_acc  ? {24'h000000, acc_r} :
        hit_st   ? {29'h0000000, status_r} :
        hit_da   ? {24'h000000, dir_r[0]} :
        hit_db   ? {24'h000000, dir_r[1]} :
        hit_dc   ? {24'h000000, dir_r[2]} : 32'h00000000;

    // ---------------------------------------------------------------
    // execute datapath: a write to the opcode register runs in that cycle
    // ---------------------------------------------------------------
    wire                    exec_en  = wr_done & hit_opc;
    nsxte_pkg::nsxte_dec_t  dec;
    assign dec = decode(pwdata[11:0]);
    wire [7:0]  src      = file_r[dec.faddr];
    wire [7:0]  swap_val = {src[3:0], src[7:4]};
    wire [7:0]  xorl_val = acc_r ^ dec.lit;
    wire [7:0]  xorf_val = acc_r ^ src;
    wire        is_swap  = exec_en & (dec.op == nsxte_pkg::NSXTE_OP_SWAP);
    wire        is_xorf  = exec_en & (dec.op == nsxte_pkg::NSXTE_OP_XORF);
    wire        is_xorl  = exec_en & (dec.op == nsxte_pkg::NSXTE_OP_XORL);
    wire        is_dirld = exec_en & (dec.op == nsxte_pkg::NSXTE_OP_DIRLD);
    wire [7:0]  alu_val  = is_swap ? swap_val : (is_xorf ? xorf_val : xorl_val);
    wire        acc_we   = ((is_swap | is_xorf) & ~dec.dest) | is_xorl;
    wire        file_we  = (is_swap | is_xorf) & dec.dest;
    wire        z_we     = is_xorf | is_xorl;
    wire        z_val    = (alu_val == 8'h00);
    wire [1:0]  dir_idx  = 2'(dec.sel - nsxte_pkg::DIR_SEL_MIN);

    // ---------------------------------------------------------------
    // apb handshake: one wait state, data and error captured with ready
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
        else
        begin
            pready_r <= access & ~pready_r;
            if (access & ~pready_r)
            begin
                pslverr_r <= ~mapped;
                prdata_r  <= pwrite ? 32'h00000000 : rdata;
            end
        end
    end

    // handshake checks: ready is a one-cycle pulse after one wait state
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready_r |=> !pready_r)
        else $error("ready held longer than one cycle");

    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !access |=> !pready_r)
        else $error("ready raised outside a transfer");

    a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_r |=> pready_r)
        else $error("ready not raised after one wait state");

    a_write_rdata: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_r && pwrite |=> prdata_r == 32'h00000000)
        else $error("read data not zero on a write");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_r && !mapped |=> pslverr_r)
        else $error("unmapped address not flagged");

    a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready_r && mapped |=> !pslverr_r)
        else $error("error flagged on a mapped address");

    // accumulator, status and last opcode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r    <= nsxte_pkg::ACC_RST;
            status_r <= nsxte_pkg::STATUS_RST;
            opcode_r <= nsxte_pkg::OPCODE_RST;
        end
        else
        begin
            if (acc_we)
                acc_r <= alu_val;
            else if (wr_done & hit_acc)
                acc_r <= pwdata[7:0];
            if (z_we)
                status_r[nsxte_pkg::ST_Z] <= z_val;
            else if (wr_done & hit_st)
                status_r <= pwdata[2:0];
            if (exec_en)
                opcode_r <= pwdata[11:0];
        end
    end

    // file registers, written by software or by an instruction result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NFILE; i++)
                file_r[i] <= nsxte_pkg::FILE_RST;
        end
        else if (file_we)
            file_r[dec.faddr] <= alu_val;
        else if (wr_done & hit_file)
            file_r[file_idx] <= pwdata[7:0];
    end

    // direction registers, loaded only by the direction load instruction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                dir_r[i] <= nsxte_pkg::DIR_RST;
        end
        else if (is_dirld)
            dir_r[dir_idx] <= acc_r;
    end

    // outputs straight from flops
    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;
    assign port_a_direction_reg = dir_r[0];
    assign port_b_direction_reg = dir_r[1];
    assign port_c_direction_reg = dir_r[2];

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    logic [7:0] alu_past;

    a_swap_nibbles: assert property (@(posedge pclk) disable iff (!presetn)
        is_swap |=> (alu_past == {$past(src[3:0]), $past(src[7:4])}))
        else $error("nibble exchange value wrong");

    // previous cycle's result, compared by the exchange and zero checks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alu_past <= 8'h00;
        else
            alu_past <= alu_val;
    end

    a_swap_to_acc: assert property (@(posedge pclk) disable iff (!presetn)
        is_swap && !dec.dest |=> acc_r == {$past(src[3:0]), $past(src[7:4])}
            && file_r[$past(dec.faddr)] == $past(src))
        else $error("exchange to accumulator wrong");

    a_swap_to_file: assert property (@(posedge pclk) disable iff (!presetn)
        is_swap && dec.dest |=> file_r[$past(dec.faddr)] == {$past(src[3:0]), $past(src[7:4])}
            && $stable(acc_r))
        else $error("exchange to file wrong");

    a_dir_load: assert property (@(posedge pclk) disable iff (!presetn)
        is_dirld |=> dir_r[$past(dir_idx)] == $past(acc_r) && $stable(status_r))
        else $error("direction load wrong");

    a_xorl_acc: assert property (@(posedge pclk) disable iff (!presetn)
        is_xorl |=> acc_r == ($past(acc_r) ^ $past(pwdata[7:0])))
        else $error("literal xor wrong");

    a_xorf_acc: assert property (@(posedge pclk) disable iff (!presetn)
        is_xorf && !dec.dest |=> acc_r == ($past(acc_r) ^ $past(src))
            && file_r[$past(dec.faddr)] == $past(src))
        else $error("register xor to accumulator wrong");

    a_xorf_file: assert property (@(posedge pclk) disable iff (!presetn)
        is_xorf && dec.dest |=> file_r[$past(dec.faddr)] == ($past(acc_r) ^ $past(src))
            && $stable(acc_r))
        else $error("register xor to file wrong");

    a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (is_xorl || is_xorf) |=> status_r[nsxte_pkg::ST_Z] == (alu_past == 8'h00)
            && status_r[1:0] == $past(status_r[1:0]))
        else $error("zero flag wrong");

    a_flags_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (is_swap || is_dirld) |=> $stable(status_r))
        else $error("flags changed by exchange or load");

    // state that must only move on its own instruction or software write
    a_dir_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !is_dirld |=> $stable(dir_r[0]) && $stable(dir_r[1]) && $stable(dir_r[2]))
        else $error("direction register changed without a load");

    a_dir_acc_kept: assert property (@(posedge pclk) disable iff (!presetn)
        is_dirld |=> $stable(acc_r))
        else $error("direction load changed the accumulator");

    a_xorl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        is_xorl |=> status_r[nsxte_pkg::ST_Z] == (($past(acc_r) ^ $past(pwdata[7:0])) == 8'h00))
        else $error("literal xor zero flag wrong");

    a_xorf_zero: assert property (@(posedge pclk) disable iff (!presetn)
        is_xorf |=> status_r[nsxte_pkg::ST_Z] == (($past(acc_r) ^ $past(src)) == 8'h00))
        else $error("register xor zero flag wrong");

    a_opcode_rec: assert property (@(posedge pclk) disable iff (!presetn)
        exec_en |=> opcode_r == $past(pwdata[11:0]))
        else $error("executed opcode not recorded");

    a_opcode_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !exec_en |=> $stable(opcode_r))
        else $error("opcode register changed without a write");

    a_unknown_op: assert property (@(posedge pclk) disable iff (!presetn)
        exec_en && dec.op == nsxte_pkg::NSXTE_OP_NONE |=> $stable(acc_r) && $stable(status_r))
        else $error("unsupported opcode changed state");

    a_strobe_off: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && !pstrb[0] |=> $stable(acc_r) && $stable(status_r))
        else $error("write without byte strobe took effect");

    a_bad_addr_wr: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && !mapped |=> $stable(acc_r) && $stable(status_r))
        else $error("write to unmapped address took effect");

    a_acc_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && hit_acc |=> acc_r == $past(pwdata[7:0]))
        else $error("software accumulator write lost");

    a_status_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && hit_st |=> status_r == $past(pwdata[2:0]))
        else $error("software status write lost");

endmodule

// ### src/nsxte_pkg.sv
// constants, types and decode patterns for the nibble swap / xor / direction load executor
//
// Operation
// - opcode 0011_10df_ffff reads file f and exchanges its two nibbles
// - nibble exchange with d=0 writes accumulator, file register stays unchanged
// - nibble exchange with d=1 writes result back into the same file register
// - opcode 0000_0000_0fff, selector 5..7, copies accumulator into that direction register
// - upper opcode bits 1111 xor accumulator with the low eight literal bits
// - literal xor result goes to the accumulator and updates the zero flag
// - opcode 0001_10df_ffff xors accumulator with file f and updates zero flag
// - register xor with d=0 writes accumulator, file register unchanged
// - register xor with d=1 writes file register, accumulator unchanged
package nsxte_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_OPCODE    = 8'h00; // write executes, read gives last opcode
    localparam logic [7:0] OFF_ACC       = 8'h04; // working accumulator
    localparam logic [7:0] OFF_STATUS    = 8'h08; // flags
    localparam logic [7:0] OFF_DIR_A     = 8'h0C; // direction register, selector 5
    localparam logic [7:0] OFF_DIR_B     = 8'h10; // direction register, selector 6
    localparam logic [7:0] OFF_DIR_C     = 8'h14; // direction register, selector 7
    localparam int         FILE_SEL_BIT  = 7;     // address bit that selects the file window
    localparam int         FILE_IDX_LSB  = 2;     // word index of a file register
    localparam int         FILE_IDX_MSB  = 6;

    // status bit positions and reset values
    localparam int         ST_C          = 0;
    localparam int         ST_DC         = 1;
    localparam int         ST_Z          = 2;
    localparam logic [2:0] STATUS_RST    = 3'h0;
    localparam logic [7:0] DIR_RST       = 8'hFF; // all pins input after reset
    localparam logic [7:0] ACC_RST       = 8'h00;
    localparam logic [7:0] FILE_RST      = 8'h00; // file registers clear after reset
    localparam logic [11:0] OPCODE_RST   = 12'h000;

    // ---------------------------------------------------------------
    // opcode patterns
    // ---------------------------------------------------------------
    localparam logic [5:0] PAT_SWAP      = 6'h0E; // 0011_10
    localparam logic [5:0] PAT_XORF      = 6'h06; // 0001_10
    localparam logic [3:0] PAT_XORL      = 4'hF;  // 1111
    localparam logic [8:0] PAT_DIRLD     = 9'h000; // 0000_0000_0
    localparam logic [2:0] DIR_SEL_MIN   = 3'h5;
    localparam int         DEST_BIT      = 5;

    typedef enum logic [2:0] {
        NSXTE_OP_NONE,
        NSXTE_OP_SWAP,
        NSXTE_OP_DIRLD,
        NSXTE_OP_XORL,
        NSXTE_OP_XORF
    } nsxte_op_t;

    // decoded instruction fields
    typedef struct packed {
        nsxte_op_t  op;
        logic       dest;    // 1: file register, 0: accumulator
        logic [4:0] faddr;
        logic [7:0] lit;
        logic [2:0] sel;
    } nsxte_dec_t;

endpackage

// ### dv/nsxte_bench.sv
// self-checking bench for the nibble swap / xor / direction load executor
`timescale 1ns/100ps
module nsxte_bench;
    typedef struct packed {
        logic [7:0]  acc0;
        logic [4:0]  fa;
        logic [7:0]  fv;
        logic [2:0]  st0;
        logic [11:0] op;
        logic [7:0]  eacc;
        logic [7:0]  efv;
        logic [2:0]  est;
    } nsxte_row_t;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  dir_a;
    logic [7:0]  dir_b;
    logic [7:0]  dir_c;
    logic [31:0] rdata;
    logic        rerr;
    int          fails;
    int          total_checks;
    nsxte_row_t  r;
    // acc, file, status preset, opcode, then expected acc, file, status
    nsxte_row_t  rows [6] = '{
        '{8'h00, 5'h03, 8'hA5, 3'h7, 12'h383, 8'h5A, 8'hA5, 3'h7},
        '{8'h11, 5'h1F, 8'h3C, 3'h0, 12'h3BF, 8'h11, 8'hC3, 3'h0},
        '{8'hB5, 5'h01, 8'h22, 3'h7, 12'hFAF, 8'h1A, 8'h22, 3'h3},
        '{8'h5A, 5'h02, 8'h33, 3'h0, 12'hF5A, 8'h00, 8'h33, 3'h4},
        '{8'hB5, 5'h00, 8'hAF, 3'h7, 12'h180, 8'h1A, 8'hAF, 3'h3},
        '{8'hB5, 5'h11, 8'hB5, 3'h3, 12'h1B1, 8'hB5, 8'h00, 3'h7}};

    nsxte_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a_direction_reg(dir_a),
        .port_b_direction_reg(dir_b), .port_c_direction_reg(dir_c));

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one apb transfer, entered and left just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
        begin
            $display("Error pready expected 1 seen %b", pready);
            fails++;
            end_of_test();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [11:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, {20'h00000, e}, rdata);
        chk("pslverr_ok", 32'h0, {31'h0, rerr});
    endtask
    task automatic dirld(input logic [7:0] v, input logic [11:0] op);
        xfer(1'b1, nsxte_pkg::OFF_ACC, {24'h000000, v});
        xfer(1'b1, nsxte_pkg::OFF_STATUS, 32'h7);
        xfer(1'b1, nsxte_pkg::OFF_OPCODE, {20'h00000, op});
        rd_chk("status", nsxte_pkg::OFF_STATUS, 12'h7);
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        fails = 0;
        total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // table of instruction cases
        foreach (rows[i])
        begin
            r = rows[i];
            xfer(1'b1, nsxte_pkg::OFF_ACC, {24'h000000, r.acc0});
            xfer(1'b1, nsxte_pkg::OFF_STATUS, {29'h0, r.st0});
            xfer(1'b1, {1'b1, r.fa, 2'b00}, {24'h000000, r.fv});
            xfer(1'b1, nsxte_pkg::OFF_OPCODE, {20'h00000, r.op});
            rd_chk("acc", nsxte_pkg::OFF_ACC, {4'h0, r.eacc});
            rd_chk("file", {1'b1, r.fa, 2'b00}, {4'h0, r.efv});
            rd_chk("status", nsxte_pkg::OFF_STATUS, {9'h000, r.est});
            $display("test row %0d done", i);
        end
        rd_chk("opcode", nsxte_pkg::OFF_OPCODE, 12'h1B1);
        // direction loads for selectors 5, 6, 7 and a rejected 4
        dirld(8'hA5, 12'h005);
        chk("dir_a", 32'hA5, {24'h000000, dir_a});
        dirld(8'h5A, 12'h006);
        chk("dir_b", 32'h5A, {24'h000000, dir_b});
        dirld(8'h3C, 12'h007);
        chk("dir_c", 32'h3C, {24'h000000, dir_c});
        dirld(8'h11, 12'h004);
        chk("dirs", 32'hA55A3C, {8'h00, dir_a, dir_b, dir_c});
        rd_chk("opcode_any", nsxte_pkg::OFF_OPCODE, 12'h004);
        xfer(1'b1, nsxte_pkg::OFF_DIR_A, 32'h0);
        rd_chk("dir_a_rd", nsxte_pkg::OFF_DIR_A, 12'h0A5);
        $display("test direction load done");
        // unmapped address answers with an error
        xfer(1'b0, 8'h18, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
        xfer(1'b1, 8'h18, 32'h5A);
        chk("pslverr_wr", 32'h1, {31'h0, rerr});
        rd_chk("acc_kept", nsxte_pkg::OFF_ACC, 12'h011);
        // a write without its low byte strobe must not land
        pstrb <= 4'h0;
        xfer(1'b1, nsxte_pkg::OFF_ACC, 32'h5A);
        pstrb <= 4'hF;
        rd_chk("acc_no_strb", nsxte_pkg::OFF_ACC, 12'h011);
        $display("test unmapped done");
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("dirs_rst", 32'hFFFFFF, {8'h00, dir_a, dir_b, dir_c});
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("acc_rst", nsxte_pkg::OFF_ACC, 12'h000);
        rd_chk("file_rst", 8'hFC, 12'h000);
        rd_chk("opcode_rst", nsxte_pkg::OFF_OPCODE, 12'h000);
        rd_chk("status_rst", nsxte_pkg::OFF_STATUS, 12'h000);
        $display("test reset done");
        end_of_test();
    end
endmodule
